// ==== hw/tisc_pkg.sv ====
// constants and register map of the timer interrupt status and clear block
// What this block does
// - status bit 8 sets whenever software writes the timer enable bit.
// - status bit 8 clears once the new enable reached the timer clock domain.
// - status bit 7 reads 1 only while upper count is frozen and freeze enabled.
// - in free running mode with rollover enable, count extreme sets status bit 3.
// - rollover flag stays set until cleared through clear register, reads leave it.
// - compare C, B, A matches set status bits 2, 1, 0 when enabled.
// - compare flags clear as a side effect of reading the status register.
// - writing 1 to clear bit 3 clears rollover flag; 0 does nothing.
// - writing 1 to clear bits 2..0 clears compare C, B, A flags.
// - written clear bits return to 0 after crossing into timer clock domain.
// - status register holds all zeros after reset.
// - with an interrupt enable low, its compare or rollover event sets no status flag.
package tisc_pkg;
    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 32;
    localparam logic [31:0] ADDR_CONTROL    = 32'h40000008;
    localparam logic [31:0] ADDR_ENABLE     = 32'h4000000C;
    localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h40000028;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4000002C;
    localparam logic [31:0] ADDR_IRQ_CLEAR  = 32'h40000030;
    localparam int          BIT_EN_SYNC     = 8;
    localparam int          BIT_FREEZE      = 7;
    localparam int          BIT_ROLL        = 3;
    localparam int          BIT_CTRL_FREEZE = 3;
    localparam int          BIT_CTRL_FREE   = 4;
    localparam int          BIT_TIMER_EN    = 0;
    localparam logic [15:0] STATUS_RESET    = 16'h0000;
    localparam logic [15:0] CONTROL_RESET   = 16'h0010;
    localparam logic [3:0]  IEN_RESET       = 4'h0;
    // timer domain runs at 32 kHz; a crossing takes two of its periods
    localparam int          TMR_PERIOD_NS   = 31250;
    localparam int          SYNC_PERIODS    = 2;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          CLR_SYNC_CYCLES = (SYNC_PERIODS * TMR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W           = 16;
endpackage

// ==== hw/tisc_sync.sv ====
// two flip-flop synchroniser for inputs from the timer clock domain
`timescale 1ns/1ps
module tisc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ==== hw/tisc_top.sv ====
// timer interrupt status, clear, enable and enable-sync logic
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module tisc_top #(
    parameter int CLR_SYNC_CYCLES = tisc_pkg::CLR_SYNC_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic [31:0] ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    output logic             IRQ,
    output logic             TIMER_EN,
    output logic             FREEZE_EN,
    output logic             FREE_RUN,
    input  wire logic        TMR_EN_SEEN,
    input  wire logic        TMR_FROZEN,
    input  wire logic        TMR_COUNT_UP,
    input  wire logic        TMR_ALL_ONES,
    input  wire logic        TMR_ALL_ZEROS,
    input  wire logic [2:0]  TMR_MATCH
);
    logic [15:0] control;
    logic [3:0]  irq_enable;
    logic        en_pend;
    logic        frozen_flag;
    logic        roll_flag;
    logic [2:0]  cmp_flag;
    logic [3:0]  clr_pend;
    logic [15:0] clr_cnt;
    logic        en_seen_s;
    logic        frozen_s;
    logic        up_s;
    logic        ones_s;
    logic        zeros_s;
    logic [2:0]  match_s;
    logic        roll_cond_q;
    logic [2:0]  match_q;
    logic        roll_cond;
    logic        roll_evt;
    logic [2:0]  match_evt;
    logic        wr_ctrl;
    logic        wr_en;
    logic        wr_ien;
    logic        wr_clr;
    logic        rd_stat;
    logic        clr_fire;
    logic [15:0] status;
    logic [15:0] next_rdata;
    logic [15:0] clr_age;

    // all timer-side levels cross into this clock first
    tisc_sync #(.WIDTH(8)) u_sync (
        .clk (CLK),
        .rst (RST),
        .ce  (CE),
        .d   ({TMR_EN_SEEN, TMR_FROZEN, TMR_COUNT_UP, TMR_ALL_ONES, TMR_ALL_ZEROS, TMR_MATCH}),
        .q   ({en_seen_s, frozen_s, up_s, ones_s, zeros_s, match_s})
    );

    assign wr_ctrl  = WR && (ADDR == tisc_pkg::ADDR_CONTROL);
    assign wr_en    = WR && (ADDR == tisc_pkg::ADDR_ENABLE);
    assign wr_ien   = WR && (ADDR == tisc_pkg::ADDR_IRQ_ENABLE);
    assign wr_clr   = WR && (ADDR == tisc_pkg::ADDR_IRQ_CLEAR);
    assign rd_stat  = RD && (ADDR == tisc_pkg::ADDR_IRQ_STATUS);
    assign clr_fire = (clr_pend != 4'h0) && (clr_cnt == 16'h0000);

    assign roll_cond = control[tisc_pkg::BIT_CTRL_FREE] && (up_s ? ones_s : zeros_s);
    assign roll_evt  = roll_cond && !roll_cond_q && irq_enable[tisc_pkg::BIT_ROLL];
    assign match_evt = match_s & ~match_q & irq_enable[2:0];

    assign status = {7'h00, en_pend, frozen_flag, 3'h0, roll_flag, cmp_flag};

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            roll_cond_q <= 1'b0;
            match_q     <= 3'h0;
        end else if (CE) begin
            roll_cond_q <= roll_cond;
            match_q     <= match_s;
        end
    end

    roll_free_a: assert property (@(posedge CLK) disable iff (RST)
        CE && !control[tisc_pkg::BIT_CTRL_FREE] && !roll_flag |=> !roll_flag)
        else $error("rollover flag set outside free running mode");
    roll_dir_a: assert property (@(posedge CLK) disable iff (RST)
        CE && !roll_flag && !(up_s ? ones_s : zeros_s) |=> !roll_flag)
        else $error("rollover flag set away from the count extreme");
    roll_gate_a: assert property (@(posedge CLK) disable iff (RST)
        CE && !irq_enable[tisc_pkg::BIT_ROLL] && !roll_flag |=> !roll_flag)
        else $error("disabled rollover set its flag");

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            control    <= tisc_pkg::CONTROL_RESET;
            irq_enable <= tisc_pkg::IEN_RESET;
            TIMER_EN   <= 1'b0;
        end else if (CE) begin
            if (wr_ctrl) begin
                control <= WDATA;
            end
            if (wr_ien) begin
                irq_enable <= WDATA[3:0];
            end
            if (wr_en) begin
                TIMER_EN <= WDATA[tisc_pkg::BIT_TIMER_EN];
            end
        end
    end

    ien_write_a: assert property (@(posedge CLK) disable iff (RST)
        CE && wr_ien |=> irq_enable == $past(WDATA[3:0]))
        else $error("interrupt enable write lost");
    timer_en_a: assert property (@(posedge CLK) disable iff (RST)
        CE && wr_en |=> TIMER_EN == $past(WDATA[tisc_pkg::BIT_TIMER_EN]))
        else $error("timer enable write lost");
    // clock enable holds state
    ce_hold_a: assert property (@(posedge CLK) disable iff (RST)
        !CE |=> (control == $past(control)) && (irq_enable == $past(irq_enable)) && (status == $past(status))
            && (TIMER_EN == $past(TIMER_EN)) && (RDATA == $past(RDATA)))
        else $error("state moved while clock enable low");

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            FREEZE_EN <= 1'b0;
            FREE_RUN  <= 1'b1;
        end else if (CE) begin
            FREEZE_EN <= control[tisc_pkg::BIT_CTRL_FREEZE];
            FREE_RUN  <= control[tisc_pkg::BIT_CTRL_FREE];
        end
    end

    // copies toward the timer side
    ctrl_copy_a: assert property (@(posedge CLK) disable iff (RST)
        CE |=> (FREEZE_EN == $past(control[tisc_pkg::BIT_CTRL_FREEZE]))
            && (FREE_RUN == $past(control[tisc_pkg::BIT_CTRL_FREE])))
        else $error("control copies out of step");

    // enable-change tracking; a write restarts the wait even with an equal value
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            en_pend <= 1'b0;
        end else if (CE) begin
            if (wr_en) begin
                en_pend <= 1'b1;
            end else if (en_seen_s == TIMER_EN) begin
                en_pend <= 1'b0;
            end
        end
    end

    en_pend_hold_a: assert property (@(posedge CLK) disable iff (RST)
        CE && en_pend && !wr_en && (en_seen_s != TIMER_EN) |=> en_pend)
        else $error("enable sync pending cleared early");
    en_pend_quiet_a: assert property (@(posedge CLK) disable iff (RST)
        CE && !en_pend && !wr_en |=> !en_pend)
        else $error("enable sync pending set without a write");

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            frozen_flag <= 1'b0;
        end else if (CE) begin
            frozen_flag <= frozen_s && control[tisc_pkg::BIT_CTRL_FREEZE];
        end
    end

    freeze_off_a: assert property (@(posedge CLK) disable iff (RST)
        CE && !frozen_s |=> !frozen_flag)
        else $error("freeze status without a frozen count");

    // clear requests wait for the timer-domain crossing time before acting
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            clr_pend <= 4'h0;
            clr_cnt  <= 16'h0000;
        end else if (CE) begin
            if (wr_clr) begin
                clr_pend <= clr_pend | WDATA[3:0];
                clr_cnt  <= 16'(CLR_SYNC_CYCLES - 1);
            end else if (clr_fire) begin
                clr_pend <= 4'h0;
            end else if (clr_cnt != 16'h0000) begin
                clr_cnt <= clr_cnt - 16'h0001;
            end
        end
    end

    // age of an unserved clear request; bounds the crossing wait checked below
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            clr_age <= 16'h0000;
        end else if (CE) begin
            if (wr_clr || (clr_pend == 4'h0)) begin
                clr_age <= 16'h0000;
            end else begin
                clr_age <= clr_age + 16'h0001;
            end
        end
    end

    clr_count_a: assert property (@(posedge CLK) disable iff (RST)
        CE && !wr_clr && (clr_cnt != 16'h0000) |=> clr_cnt == $past(clr_cnt) - 16'h0001)
        else $error("clear crossing count stalled");
    clr_load_a: assert property (@(posedge CLK) disable iff (RST)
        CE && wr_clr |=> (clr_cnt == 16'(CLR_SYNC_CYCLES - 1))
            && (clr_pend == ($past(clr_pend) | $past(WDATA[3:0]))))
        else $error("clear write not taken");
    clr_zero_a: assert property (@(posedge CLK) disable iff (RST)
        CE && wr_clr && (WDATA[3:0] == 4'h0) && (clr_pend == 4'h0) |=> clr_pend == 4'h0)
        else $error("zero clear write raised a request");
    clr_bound_a: assert property (@(posedge CLK) disable iff (RST)
        clr_pend != 4'h0 |-> clr_age < 16'(CLR_SYNC_CYCLES))
        else $error("clear request waited too long");

    // an event in the clearing cycle survives: set wins over clear
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            roll_flag <= tisc_pkg::STATUS_RESET[tisc_pkg::BIT_ROLL];
            cmp_flag  <= tisc_pkg::STATUS_RESET[2:0];
        end else if (CE) begin
            if (roll_evt) begin
                roll_flag <= 1'b1;
            end else if (clr_fire && clr_pend[tisc_pkg::BIT_ROLL]) begin
                roll_flag <= 1'b0;
            end
            cmp_flag <= match_evt | (cmp_flag & ~(rd_stat ? 3'h7 : 3'h0) & ~(clr_fire ? clr_pend[2:0] : 3'h0));
        end
    end

    roll_clr_a: assert property (@(posedge CLK) disable iff (RST)
        CE && clr_fire && clr_pend[tisc_pkg::BIT_ROLL] && !roll_evt |=> !roll_flag)
        else $error("rollover clear ignored");
    roll_read_a: assert property (@(posedge CLK) disable iff (RST)
        CE && rd_stat && roll_flag && !clr_fire |=> roll_flag)
        else $error("status read cleared rollover");
    cmp_set_a: assert property (@(posedge CLK) disable iff (RST)
        CE |=> (cmp_flag & $past(match_evt)) == $past(match_evt))
        else $error("compare event lost");
    cmp_gate_a: assert property (@(posedge CLK) disable iff (RST)
        CE |=> (cmp_flag & ~$past(cmp_flag) & ~$past(irq_enable[2:0])) == 3'h0)
        else $error("disabled compare set its flag");
    cmp_hold_a: assert property (@(posedge CLK) disable iff (RST)
        CE && !rd_stat && !clr_fire |=> (cmp_flag & $past(cmp_flag)) == $past(cmp_flag))
        else $error("compare flag dropped without read or clear");

    always_comb begin
        next_rdata = 16'h0000;
        case (ADDR)
            tisc_pkg::ADDR_CONTROL:    next_rdata = control;
            tisc_pkg::ADDR_ENABLE:     next_rdata = {15'h0000, TIMER_EN};
            tisc_pkg::ADDR_IRQ_ENABLE: next_rdata = {12'h000, irq_enable};
            tisc_pkg::ADDR_IRQ_STATUS: next_rdata = status;
            default:                   next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 16'h0000;
            IRQ   <= 1'b0;
        end else if (CE) begin
            RDATA <= RD ? next_rdata : 16'h0000;
            IRQ   <= |({roll_flag, cmp_flag} & irq_enable);
        end
    end

    // read data stand one cycle
    rdata_idle_a: assert property (@(posedge CLK) disable iff (RST)
        CE && !RD |=> RDATA == 16'h0000)
        else $error("read data outside read cycle");
    rdata_resv_a: assert property (@(posedge CLK) disable iff (RST)
        CE && rd_stat |=> (RDATA[15:9] == 7'h00) && (RDATA[6:4] == 3'h0))
        else $error("reserved status bits not zero");
    // interrupt enable register readback
    rdata_ien_a: assert property (@(posedge CLK) disable iff (RST)
        CE && RD && (ADDR == tisc_pkg::ADDR_IRQ_ENABLE) |=> RDATA == {12'h000, $past(irq_enable)})
        else $error("interrupt enable readback wrong");
    reset_out_a: assert property (@(posedge CLK) disable iff (RST)
        $past(RST) |-> (RDATA == 16'h0000) && !IRQ && !TIMER_EN && !FREEZE_EN && FREE_RUN)
        else $error("outputs not idle after reset");

    en_pend_set_a: assert property (@(posedge CLK) disable iff (RST)
        CE && wr_en |=> status[tisc_pkg::BIT_EN_SYNC])
        else $error("enable sync pending did not set");
    en_pend_clr_a: assert property (@(posedge CLK) disable iff (RST)
        CE && en_pend && !wr_en && (en_seen_s == TIMER_EN) |=> !en_pend)
        else $error("enable sync pending stuck");
    freeze_bit_a: assert property (@(posedge CLK) disable iff (RST)
        CE |=> frozen_flag == ($past(frozen_s) && $past(control[tisc_pkg::BIT_CTRL_FREEZE])))
        else $error("freeze status without freeze");
    roll_set_a: assert property (@(posedge CLK) disable iff (RST)
        CE && roll_cond && !roll_cond_q && irq_enable[3] |=> roll_flag)
        else $error("rollover flag missed");
    roll_hold_a: assert property (@(posedge CLK) disable iff (RST)
        CE && roll_flag && !(clr_fire && clr_pend[3]) |=> roll_flag)
        else $error("rollover flag lost");
    match_gate_a: assert property (@(posedge CLK) disable iff (RST)
        CE && !irq_enable[0] && !cmp_flag[0] |=> !cmp_flag[0])
        else $error("disabled compare set its flag");
    read_clr_a: assert property (@(posedge CLK) disable iff (RST)
        CE && rd_stat && (match_evt == 3'h0) |=> cmp_flag == 3'h0 ##0 RDATA == $past(status))
        else $error("status read did not clear compare flags");
    clr_apply_a: assert property (@(posedge CLK) disable iff (RST)
        CE && clr_fire && clr_pend[1] && !match_evt[1] |=> !cmp_flag[1])
        else $error("compare clear ignored");
    clr_self_a: assert property (@(posedge CLK) disable iff (RST)
        CE && clr_fire && !wr_clr |=> clr_pend == 4'h0)
        else $error("clear bits did not self clear");
    reset_zero_a: assert property (@(posedge CLK) disable iff (RST)
        $past(RST) |-> status == tisc_pkg::STATUS_RESET)
        else $error("status not zero after reset");
    irq_level_a: assert property (@(posedge CLK) disable iff (RST)
        CE |=> IRQ == |($past({roll_flag, cmp_flag}) & $past(irq_enable)))
        else $error("interrupt output wrong");
endmodule

// ==== testbench/tb_tisc_top.sv ====
// self-checking bench for the timer interrupt status and clear block
`timescale 1ns/1ps
module tb_tisc_top;
    // short clear crossing keeps the run brief
    localparam int          CLR_CYC = 4;
    localparam logic [31:0] A_CT    = tisc_pkg::ADDR_CONTROL;
    localparam logic [31:0] A_EN    = tisc_pkg::ADDR_ENABLE;
    localparam logic [31:0] A_IE    = tisc_pkg::ADDR_IRQ_ENABLE;
    localparam logic [31:0] A_ST    = tisc_pkg::ADDR_IRQ_STATUS;
    localparam logic [31:0] A_CL    = tisc_pkg::ADDR_IRQ_CLEAR;
    logic        CLK;
    logic        RST;
    logic        CE;
    logic [31:0] ADDR;
    logic [15:0] WDATA;
    logic        WR;
    logic        RD;
    logic [15:0] RDATA;
    logic        IRQ;
    logic        TIMER_EN;
    logic        FREEZE_EN;
    logic        FREE_RUN;
    logic        TMR_EN_SEEN;
    logic        TMR_FROZEN;
    logic        TMR_COUNT_UP;
    logic        TMR_ALL_ONES;
    logic        TMR_ALL_ZEROS;
    logic [2:0]  TMR_MATCH;
    int          bad_count;
    int          total_checks;
    int          cycles = 0;

    tisc_top #(.CLR_SYNC_CYCLES(CLR_CYC)) tisc_top_i (
        .CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .IRQ(IRQ), .TIMER_EN(TIMER_EN), .FREEZE_EN(FREEZE_EN), .FREE_RUN(FREE_RUN),
        .TMR_EN_SEEN(TMR_EN_SEEN), .TMR_FROZEN(TMR_FROZEN), .TMR_COUNT_UP(TMR_COUNT_UP),
        .TMR_ALL_ONES(TMR_ALL_ONES), .TMR_ALL_ZEROS(TMR_ALL_ZEROS), .TMR_MATCH(TMR_MATCH)
    );

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // a hung bench ends as a failure
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk(RDATA, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge CLK);
    endtask

    initial begin
        RST = 1'b1;
        CE = 1'b1;
        ADDR = 32'h00000000;
        WDATA = 16'h0000;
        WR = 1'b0;
        RD = 1'b0;
        TMR_EN_SEEN = 1'b0;
        TMR_FROZEN = 1'b0;
        TMR_COUNT_UP = 1'b1;
        TMR_ALL_ONES = 1'b0;
        TMR_ALL_ZEROS = 1'b0;
        TMR_MATCH = 3'h0;
        bad_count = 0;
        total_checks = 0;
        idle(16);
        RST <= 1'b0;
        rd(A_ST, 16'h0000);
        rd(A_CT, 16'h0010);
        rd(A_CL, 16'h0000);
        rd(32'h40000034, 16'h0000);
        chk({15'h0000, IRQ}, 16'h0000);
        chk({15'h0000, FREE_RUN}, 16'h0001);
        // one compare event per channel; a second read finds it gone
        wr(A_IE, 16'h0007);
        for (int i = 0; i < 3; i++) begin
            TMR_MATCH <= 3'(1 << i);
            idle(8);
            chk({15'h0000, IRQ}, 16'h0001);
            rd(A_ST, 16'(1 << i));
            rd(A_ST, 16'h0000);
            TMR_MATCH <= 3'h0;
            idle(6);
        end
        TMR_MATCH <= 3'b011;
        idle(8);
        wr(A_CL, 16'h0002);
        idle(CLR_CYC + 4);
        rd(A_ST, 16'h0001);
        TMR_MATCH <= 3'h0;
        // events while gated are dropped, not remembered
        wr(A_IE, 16'h0000);
        TMR_MATCH <= 3'b111;
        idle(8);
        wr(A_IE, 16'h0007);
        idle(6);
        rd(A_ST, 16'h0000);
        TMR_MATCH <= 3'h0;
        wr(A_IE, 16'h0008);
        TMR_ALL_ONES <= 1'b1;
        idle(8);
        TMR_ALL_ONES <= 1'b0;
        rd(A_ST, 16'h0008);
        rd(A_ST, 16'h0008);
        chk({15'h0000, IRQ}, 16'h0001);
        wr(A_CL, 16'h0000);
        idle(CLR_CYC + 4);
        rd(A_ST, 16'h0008);
        wr(A_CL, 16'h0008);
        idle(CLR_CYC + 4);
        rd(A_ST, 16'h0000);
        chk({15'h0000, IRQ}, 16'h0000);
        // counting down: all ones is no rollover, all zeros is
        TMR_COUNT_UP <= 1'b0;
        TMR_ALL_ONES <= 1'b1;
        idle(8);
        TMR_ALL_ONES <= 1'b0;
        rd(A_ST, 16'h0000);
        TMR_ALL_ZEROS <= 1'b1;
        idle(8);
        TMR_ALL_ZEROS <= 1'b0;
        rd(A_ST, 16'h0008);
        wr(A_CL, 16'h0008);
        idle(CLR_CYC + 4);
        rd(A_ST, 16'h0000);
        // a served clear must not eat the next rollover
        TMR_ALL_ZEROS <= 1'b1;
        idle(8);
        TMR_ALL_ZEROS <= 1'b0;
        rd(A_ST, 16'h0008);
        wr(A_CL, 16'h0008);
        idle(CLR_CYC + 4);
        rd(A_ST, 16'h0000);
        wr(A_CT, 16'h0000);
        TMR_ALL_ZEROS <= 1'b1;
        idle(8);
        TMR_ALL_ZEROS <= 1'b0;
        rd(A_ST, 16'h0000);
        chk({15'h0000, FREE_RUN}, 16'h0000);
        // enable changes stay pending until the timer side echoes them
        wr(A_EN, 16'h0001);
        rd(A_ST, 16'h0100);
        rd(A_EN, 16'h0001);
        chk({15'h0000, TIMER_EN}, 16'h0001);
        TMR_EN_SEEN <= 1'b1;
        idle(6);
        rd(A_ST, 16'h0000);
        wr(A_EN, 16'h0000);
        rd(A_ST, 16'h0100);
        chk({15'h0000, TIMER_EN}, 16'h0000);
        TMR_EN_SEEN <= 1'b0;
        idle(6);
        rd(A_ST, 16'h0000);
        wr(A_CT, 16'h0018);
        TMR_FROZEN <= 1'b1;
        idle(6);
        chk({15'h0000, FREEZE_EN}, 16'h0001);
        rd(A_ST, 16'h0080);
        wr(A_CT, 16'h0010);
        idle(4);
        rd(A_ST, 16'h0000);
        wr(A_CT, 16'h0018);
        TMR_FROZEN <= 1'b0;
        idle(6);
        rd(A_ST, 16'h0000);
        // strobes are ignored while the clock enable is low
        CE <= 1'b0;
        wr(A_IE, 16'h0000);
        CE <= 1'b1;
        rd(A_IE, 16'h0008);
        end_sim();
    end
endmodule
